//--- shared/rx_strength_map.vh
`ifndef RX_STRENGTH_MAP_VH
`define RX_STRENGTH_MAP_VH
// register byte offsets
`define OFS_MODE      8'h00
`define OFS_RXFILT    8'h04
`define OFS_DEV       8'h08
`define OFS_THRESH    8'h0c
`define OFS_STRENGTH  8'h10
`define OFS_IRQSTAT   8'h14
`define OFS_IRQMASK   8'h18
`define OFS_ROUTE     8'h1c
`define OFS_SYNC      8'h20
// field positions in filter register
`define RXF_PASSIVE_LSB  0
`define RXF_ACTIVE_LSB   4
`define RXF_POLY_BIT     8
`define RXF_CENTER_LSB   12
`define RXF_GAIN_LSB     16
// mode codes
`define MODE_RECEIVE     3'h3
// data path modes
`define DMODE_CONT       2'h0
`define DMODE_BUFFERED   2'h1
`define DMODE_PACKET     2'h2
// reset values
`define RST_MODE         3'h0
`define RST_GAIN         2'h0
`define RST_DEV          8'h03
`define RST_THRESH       8'h00
`define RST_CENTER       4'h3
// estimator constants
`define SAMPLES_PER_PER  16
`define WINDOW_LEN       16
// sampling: interval = 2*(1+dev) crystal-derived ticks, per = 16 intervals
`define SAMPLE_TICKS_MIN 16'h0002
`endif

//--- rtl/sample_timer.v
`timescale 1ns/1ps
`default_nettype none
// sample strobe, 16 per deviation period
module sample_timer #(
  parameter CW = 16
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          run,
  input  wire [7:0]    devSetting,
  output reg           sampleTick_ff
);
  reg  [CW-1:0] cnt_ff;
  wire [CW-1:0] limit;
  // interval grows with deviation code, period = 16 * interval
  assign limit = {{(CW-9){1'b0}}, ({1'b0, devSetting} + 9'h001)} << 1;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff        <= {CW{1'b0}};
      sampleTick_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff        <= {CW{1'b0}};
      sampleTick_ff <= 1'b0;
    end else if (cnt_ff + {{(CW-1){1'b0}}, 1'b1} >= limit) begin
      cnt_ff        <= {CW{1'b0}};
      sampleTick_ff <= 1'b1;
    end else begin
      cnt_ff        <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
      sampleTick_ff <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- rtl/window_avg.v
`timescale 1ns/1ps
`default_nettype none
// sliding average of the last DEPTH samples
module window_avg #(
  parameter W     = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire          push,
  input  wire [W-1:0]  sample,
  output reg  [W-1:0]  average_ff
);
  reg  [W-1:0]    hist_ff [0:DEPTH-1];
  reg  [AW-1:0]   idx_ff;
  reg  [W+AW-1:0] sum_ff;
  wire [W+AW-1:0] nxt_sum;
  integer i;
  assign nxt_sum = sum_ff + {{AW{1'b0}}, sample}
                   - {{AW{1'b0}}, hist_ff[idx_ff]};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < DEPTH; i = i + 1)
        hist_ff[i] <= {W{1'b0}};
      idx_ff     <= {AW{1'b0}};
      sum_ff     <= {(W+AW){1'b0}};
      average_ff <= {W{1'b0}};
    end else if (push) begin
      hist_ff[idx_ff] <= sample;
      idx_ff          <= idx_ff + {{(AW-1){1'b0}}, 1'b1};
      sum_ff          <= nxt_sum;
      average_ff      <= nxt_sum[W+AW-1:AW];
    end
  end
endmodule
`default_nettype wire

//--- rtl/rx_signal_strength_irq.v
// How it works
// - receive runs only while the operating mode select field holds 011.
// - gain field code n selects -4.5*n dB, from 0 down to -13.5 dB.
// - gain field resets to code 0, meaning 0 dB.
// - polyphase enable picks low-pass FSK or polyphase OOK active filter.
// - passive filter bandwidth field sets the passive filter single-side width.
// - OOK estimator samples 16 times per second intermediate period.
// - FSK estimator samples 16 times per deviation period.
// - 16-sample sliding average, value refreshed on every sample.
// - strength value is in 0.5 dB steps per bit.
// - level above threshold raises the strength interrupt condition.
// - writing one clears the strength flag; zero leaves it.
// - two route bits steer the strength interrupt to pin 0 or 1.
// - continuous mode drives synchronous clock and data to the controller.
// - buffered mode hands glitch-free synchronised bits to the FIFO.
// - timing recovery forced on in buffered or packet mode.
//
// The register addresses and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rx_strength_map.vh"
module rx_signal_strength_irq #(
  parameter SW = 8
) (
  input  wire          clk,
  input  wire          reset_n,
  input  wire [31:0]   haddr,
  input  wire [1:0]    htrans,
  input  wire          hwrite,
  input  wire [2:0]    hsize,
  input  wire [31:0]   hwdata,
  input  wire          hsel,
  input  wire          hready,
  output reg  [31:0]   hrdata,
  output reg           hreadyout,
  output reg           hresp,
  input  wire [SW-1:0] levelIn,
  input  wire          demodBit,
  output reg           rxActive,
  output reg  [1:0]    ifGainCode,
  output reg           polyphaseOn,
  output reg  [3:0]    passiveBw,
  output reg  [3:0]    activeCutoff,
  output reg  [3:0]    polyCenter,
  output reg           syncClkOut,
  output reg           syncDataOut,
  output reg           fifoPush,
  output reg           fifoBit,
  output reg           interruptPin0,
  output reg           interruptPin1,
  output reg           irq
);
  // bus address phase capture
  reg        wrPend_ff;
  reg        rdPend_ff;
  reg  [7:0] addr_ff;
  // control registers
  reg  [2:0] opMode_ff;
  reg  [1:0] gain_ff;
  reg        poly_ff;
  reg  [3:0] passive_ff;
  reg  [3:0] active_ff;
  reg  [3:0] center_ff;
  reg  [7:0] dev_ff;
  reg  [SW-1:0] thresh_ff;
  reg        flag_ff;
  reg        mask_ff;
  reg  [1:0] route_ff;
  reg  [1:0] dataMode_ff;
  reg        syncOff_ff;
  // input synchronisers
  reg  [SW-1:0] lvlMeta_ff;
  reg  [SW-1:0] lvlSync_ff;
  reg        bitMeta_ff;
  reg        bitSync_ff;
  // recovery stage
  reg        prevBit_ff;
  reg  [3:0] phase_ff;
  wire [SW-1:0] strength;
  wire       sampleTick;
  wire       receiving;
  wire       syncOn;
  wire       addrPhase;
  wire       clearHit;
  wire       setHit;

  // buffered and packet modes feed the fifo
  function is_framed;
    input [1:0] mode;
    begin
      is_framed = (mode != `DMODE_CONT);
    end
  endfunction

  // filter register read image
  function [31:0] pack_filter;
    input [1:0] gain;
    input [3:0] center;
    input       poly;
    input [3:0] active;
    input [3:0] passive;
    begin
      pack_filter = {14'h0, gain, center, 3'h0, poly, active, passive};
    end
  endfunction

  // sync control read image
  function [31:0] pack_sync;
    input       off;
    input [1:0] mode;
    begin
      pack_sync = {27'h0, off, 2'h0, mode};
    end
  endfunction

  // level for one interrupt pin
  function route_level;
    input flag;
    input sel;
    begin
      route_level = flag & sel;
    end
  endfunction

  assign addrPhase = hsel & hready & htrans[1];
  assign receiving = (opMode_ff == `MODE_RECEIVE);
  // forced on in buffered or packet mode
  assign syncOn = ~syncOff_ff | is_framed(dataMode_ff);

  // same period source serves IF2 (OOK) and deviation (FSK)
  sample_timer #(
    .CW (16)
  ) u_timer (
    .clk           (clk),
    .reset_n       (reset_n),
    .run           (receiving),
    .devSetting    (dev_ff),
    .sampleTick_ff (sampleTick)
  );

  // level input already coded at half-dB per bit
  window_avg #(
    .W     (SW),
    .DEPTH (`WINDOW_LEN),
    .AW    (4)
  ) u_avg (
    .clk        (clk),
    .reset_n    (reset_n),
    .push       (sampleTick),
    .sample     (lvlSync_ff),
    .average_ff (strength)
  );

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lvlMeta_ff <= {SW{1'b0}};
      lvlSync_ff <= {SW{1'b0}};
      bitMeta_ff <= 1'b0;
      bitSync_ff <= 1'b0;
    end else begin
      lvlMeta_ff <= levelIn;
      lvlSync_ff <= lvlMeta_ff;
      bitMeta_ff <= demodBit;
      bitSync_ff <= bitMeta_ff;
    end
  end

  assign setHit   = receiving & (strength > thresh_ff);
  assign clearHit = wrPend_ff & (addr_ff == `OFS_IRQSTAT) & hwdata[0];

  // bus slave, zero wait states
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_ff <= 1'b0;
      rdPend_ff <= 1'b0;
      addr_ff   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_ff <= addrPhase & hwrite;
      rdPend_ff <= addrPhase & ~hwrite;
      if (addrPhase) begin
        addr_ff <= haddr[7:0];
      end
    end
  end

  // register writes
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      opMode_ff   <= `RST_MODE;
      gain_ff     <= `RST_GAIN;
      poly_ff     <= 1'b0;
      passive_ff  <= 4'h0;
      active_ff   <= 4'h0;
      center_ff   <= `RST_CENTER;
      dev_ff      <= `RST_DEV;
      thresh_ff   <= {SW{1'b0}};
      mask_ff     <= 1'b0;
      route_ff    <= 2'h0;
      dataMode_ff <= `DMODE_CONT;
      syncOff_ff  <= 1'b0;
    end else if (wrPend_ff) begin
      case (addr_ff)
        `OFS_MODE: begin
          opMode_ff <= hwdata[2:0];
        end
        `OFS_RXFILT: begin
          passive_ff <= hwdata[`RXF_PASSIVE_LSB +: 4];
          active_ff  <= hwdata[`RXF_ACTIVE_LSB +: 4];
          poly_ff    <= hwdata[`RXF_POLY_BIT];
          center_ff  <= hwdata[`RXF_CENTER_LSB +: 4];
          gain_ff    <= hwdata[`RXF_GAIN_LSB +: 2];
        end
        `OFS_DEV: begin
          dev_ff <= hwdata[7:0];
        end
        `OFS_THRESH: begin
          thresh_ff <= hwdata[SW-1:0];
        end
        `OFS_IRQMASK: begin
          mask_ff <= hwdata[0];
        end
        `OFS_ROUTE: begin
          route_ff <= hwdata[1:0];
        end
        `OFS_SYNC: begin
          dataMode_ff <= hwdata[1:0];
          syncOff_ff  <= hwdata[4];
        end
        default: begin
          opMode_ff <= opMode_ff;
        end
      endcase
    end
  end

  // sticky flag, set wins over clear
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_ff <= 1'b0;
    end else if (setHit) begin
      flag_ff <= 1'b1;
    end else if (clearHit) begin
      flag_ff <= 1'b0;
    end
  end

  // read mux
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase & ~hwrite) begin
      case (haddr[7:0])
        `OFS_MODE:     hrdata <= {29'h0, opMode_ff};
        `OFS_RXFILT:   hrdata <= pack_filter(gain_ff, center_ff, poly_ff,
                                             active_ff, passive_ff);
        `OFS_DEV:      hrdata <= {24'h0, dev_ff};
        `OFS_THRESH:   hrdata <= {{(32-SW){1'b0}}, thresh_ff};
        `OFS_STRENGTH: hrdata <= {{(32-SW){1'b0}}, strength};
        `OFS_IRQSTAT:  hrdata <= {31'h0, flag_ff};
        `OFS_IRQMASK:  hrdata <= {31'h0, mask_ff};
        `OFS_ROUTE:    hrdata <= {30'h0, route_ff};
        `OFS_SYNC:     hrdata <= pack_sync(syncOff_ff, dataMode_ff);
        default:       hrdata <= 32'h00000000;
      endcase
    end
  end

  // symbol timing recovery: resample at mid-bit, realign on edges
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prevBit_ff  <= 1'b0;
      phase_ff    <= 4'h0;
      syncClkOut  <= 1'b0;
      syncDataOut <= 1'b0;
      fifoPush    <= 1'b0;
      fifoBit     <= 1'b0;
    end else begin
      prevBit_ff <= bitSync_ff;
      fifoPush   <= 1'b0;
      if (!(receiving & syncOn)) begin
        phase_ff   <= 4'h0;
        syncClkOut <= 1'b0;
      end else begin
        if (bitSync_ff != prevBit_ff) begin
          phase_ff <= 4'h0;
        end else begin
          phase_ff <= phase_ff + 4'h1;
        end
        if (phase_ff == 4'h7) begin
          syncClkOut  <= ~is_framed(dataMode_ff);
          syncDataOut <= bitSync_ff;
          fifoPush    <= is_framed(dataMode_ff);
          fifoBit     <= bitSync_ff;
        end else if (phase_ff == 4'hf) begin
          syncClkOut <= 1'b0;
        end
      end
    end
  end

  // receive indication
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxActive <= 1'b0;
    end else begin
      rxActive <= receiving;
    end
  end

  // front-end control
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ifGainCode    <= `RST_GAIN;
      polyphaseOn   <= 1'b0;
      passiveBw     <= 4'h0;
      activeCutoff  <= 4'h0;
      polyCenter    <= `RST_CENTER;
    end else begin
      ifGainCode    <= gain_ff;
      polyphaseOn   <= poly_ff;
      passiveBw     <= passive_ff;
      activeCutoff  <= active_ff;
      polyCenter    <= center_ff;
    end
  end

  // interrupt pins and level interrupt
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interruptPin0 <= 1'b0;
      interruptPin1 <= 1'b0;
      irq           <= 1'b0;
    end else begin
      interruptPin0 <= route_level(flag_ff, route_ff[0]);
      interruptPin1 <= route_level(flag_ff, route_ff[1]);
      irq           <= flag_ff & mask_ff;
    end
  end
endmodule
`default_nettype wire

//--- testbench/rx_strength_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rx_strength_checker (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hsel,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxActive,
  input wire logic [1:0]  ifGainCode,
  input wire logic        polyphaseOn,
  input wire logic [3:0]  polyCenter,
  input wire logic        fifoPush,
  input wire logic        interruptPin0,
  input wire logic        irq
);
  logic       tk;
  logic [7:0] wa [0:3];
  logic       wMode, wFilt, wPin, wIrq;
  assign tk = hsel & hready & htrans[1];
  // write addresses seen in the last four cycles
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wa <= '{default: 8'hff};
    end else begin
      wa <= '{(tk && hwrite) ? haddr[7:0] : 8'hff, wa[0], wa[1], wa[2]};
    end
  end
  always_comb begin
    wMode = 1'b0;
    wFilt = 1'b0;
    wPin = 1'b0;
    wIrq = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wMode |= wa[i] == 8'h00;
      wFilt |= wa[i] == 8'h04;
      wPin |= wa[i] == 8'h14 || wa[i] == 8'h1c;
      wIrq |= wa[i] == 8'h14 || wa[i] == 8'h18;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or error");
  a_gain_reset: assert property (
    $rose(reset_n) |-> ifGainCode == 2'h0 && polyCenter == 4'h3)
    else $error("gain or centre not at reset value");
  a_mode_cause: assert property (
    $changed(rxActive) |-> wMode)
    else $error("receive changed without mode write");
  a_filter_cause: assert property (
    $changed({ifGainCode, polyphaseOn, polyCenter}) |-> wFilt)
    else $error("filter output changed without write");
  a_pin_sticky: assert property (
    $fell(interruptPin0) |-> wPin)
    else $error("pin0 dropped without clear or route");
  a_irq_sticky: assert property (
    $fell(irq) |-> wIrq)
    else $error("irq dropped without clear or mask");
  a_unmapped_zero: assert property (
    tk && !hwrite && haddr == 32'h40 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_push_pulse: assert property (
    fifoPush |=> !fifoPush)
    else $error("fifo push longer than one cycle");
endmodule
bind rx_signal_strength_irq rx_strength_checker props (
  .clk(clk), .reset_n(reset_n), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsel(hsel), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rxActive(rxActive),
  .ifGainCode(ifGainCode), .polyphaseOn(polyphaseOn),
  .polyCenter(polyCenter), .fifoPush(fifoPush),
  .interruptPin0(interruptPin0), .irq(irq));
`default_nettype wire

//--- testbench/rf_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module rf_front_model (
  input  wire logic       clk,
  input  wire logic [7:0] level,
  output var  logic [7:0] levelIn,
  output var  logic       demodBit
);
  logic [3:0] cnt = 4'h0;
  initial demodBit = 1'b0;
  // alternating bits, 16 clocks each
  always @(posedge clk) begin
    levelIn <= level;
    cnt <= cnt + 4'h1;
    if (cnt == 4'hf) begin
      demodBit <= ~demodBit;
    end
  end
endmodule
`default_nettype wire

//--- testbench/rx_signal_strength_irq_test.sv
`timescale 1ns/1ps
`default_nettype none
module rx_signal_strength_irq_test;
  logic        clk, reset_n, hwrite, hsel;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, q, d, seed;
  logic [7:0]  level, lv, lv2;
  wire  [31:0] hrdata;
  wire         hready, rxActive, polyphaseOn, syncClkOut, fifoPush;
  wire         interruptPin0, interruptPin1, irq, demodBit;
  wire         syncDataOut, fifoBit;
  wire  [7:0]  levelIn;
  wire  [1:0]  ifGainCode;
  wire  [3:0]  passiveBw, activeCutoff, polyCenter;
  int          n_mismatch, num_checks, p, s;
  rf_front_model fe (.clk(clk), .level(level), .levelIn(levelIn),
                     .demodBit(demodBit));
  rx_signal_strength_irq uut (
    .clk(clk), .reset_n(reset_n), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hsel(hsel),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .levelIn(levelIn), .demodBit(demodBit), .rxActive(rxActive),
    .ifGainCode(ifGainCode), .polyphaseOn(polyphaseOn),
    .passiveBw(passiveBw), .activeCutoff(activeCutoff),
    .polyCenter(polyCenter), .syncClkOut(syncClkOut),
    .syncDataOut(syncDataOut),
    .fifoPush(fifoPush), .fifoBit(fifoBit), .interruptPin0(interruptPin0),
    .interruptPin1(interruptPin1), .irq(irq));
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic rx_exp(input int m);
    return m == 3;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (num_checks > 0 && n_mismatch == 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wt();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, dw);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wt();
    htrans <= 2'h0;
    hwdata <= dw;
    wt();
    q = hrdata;
  endtask
  task automatic cnt();
    p = 0;
    s = 0;
    repeat (200) begin
      @(posedge clk);
      if (fifoPush === 1'b1) begin
        chk("fbit", fifoBit, demodBit);
      end
      if (syncClkOut === 1'b1 && s == 0) begin
        chk("sdat", syncDataOut, demodBit);
      end
      p += (fifoPush === 1'b1);
      s += (syncClkOut === 1'b1);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    seed = 32'h5d;
    {reset_n, hsel, hwrite, htrans, haddr, hwdata, level} = '0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(0, 32'h04, 0); chk("filt", q, 32'h3000);
    for (int m = 0; m < 8; m++) begin
      bus(1, 32'h0, m);
      repeat (2) @(posedge clk);
      chk("rx", rxActive, rx_exp(m));
    end
    for (int g = 0; g < 4; g++) begin
      d = (xs() & 32'h0000f1ff) | (32'(g) << 16);
      bus(1, 32'h04, d);
      repeat (2) @(posedge clk);
      chk("gain", ifGainCode, d[17:16]);
      chk("poly", polyphaseOn, d[8]);
      chk("pass", passiveBw, d[3:0]);
      chk("cut", activeCutoff, d[7:4]);
      chk("ctr", polyCenter, d[15:12]);
    end
    d = xs();
    lv = d[7:0] | 8'h10;
    lv2 = lv ^ 8'h80;
    level <= lv;
    bus(1, 32'h08, 0);
    bus(1, 32'h0, 3);
    repeat (80) @(posedge clk);
    bus(0, 32'h10, 0); chk("str", q, lv);
    bus(1, 32'h08, 7);
    level <= lv2;
    repeat (80) @(posedge clk);
    bus(0, 32'h10, 0); chk("slow", q != lv2, 1);
    repeat (300) @(posedge clk);
    bus(0, 32'h10, 0); chk("str2", q, lv2);
    bus(1, 32'h0c, 32'hff);
    bus(1, 32'h14, 1);
    bus(1, 32'h18, 1);
    bus(1, 32'h1c, 1);
    bus(0, 32'h14, 0); chk("flag0", q, 0);
    bus(1, 32'h0c, lv2 - 8'h1);
    repeat (4) @(posedge clk);
    chk("irq", irq, 1);
    chk("pin0", interruptPin0, 1);
    chk("pin1", interruptPin1, 0);
    level <= 8'h0;
    repeat (300) @(posedge clk);
    chk("hold", irq, 1);
    bus(1, 32'h1c, 2);
    repeat (2) @(posedge clk);
    chk("pin0b", interruptPin0, 0);
    chk("pin1b", interruptPin1, 1);
    bus(1, 32'h14, 0);
    repeat (2) @(posedge clk);
    chk("w0", irq, 1);
    bus(1, 32'h18, 0);
    repeat (2) @(posedge clk);
    chk("mask", irq, 0);
    bus(1, 32'h14, 1);
    bus(0, 32'h14, 0); chk("w1c", q, 0);
    bus(1, 32'h40, 32'hffff);
    bus(0, 32'h40, 0); chk("unmap", q, 0);
    bus(0, 32'h0c, 0); chk("thr", q, lv2 - 8'h1);
    bus(1, 32'h20, 32'h11);
    cnt();
    chk("push", p > 0, 1);
    chk("sclk", s, 0);
    bus(1, 32'h20, 0);
    cnt();
    chk("sclk2", s > 0, 1);
    chk("push2", p, 0);
    bus(1, 32'h04, 32'h3100);
    bus(1, 32'h08, 32'h3);
    bus(0, 32'h08, 0); chk("dev", q, 32'h3);
    bus(0, 32'h04, 0); chk("filt2", q, 32'h3100);
    repeat (2) @(posedge clk);
    chk("ook", polyphaseOn, 1);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk("gainr", ifGainCode, 0);
    stop_test();
  end
endmodule
`default_nettype wire
